// File: verilog/txcfg_pkg.sv
// Shared constants for the transmitter configuration loader and its controller.
`default_nettype none
package txcfg_pkg;
   // Word layout.
   localparam int WORD_BITS       = 32;
   localparam int POS_CLK_ONLY    = 31;
   localparam int POS_BAND_HIGH   = 30;
   localparam int POS_CARRIER_ADJUST_WORD_LSB    = 15;
   localparam int CARRIER_ADJUST_WORD_BITS       = 15;
   localparam int POS_DEV_LSB     = 7;
   localparam int DEV_BITS        = 8;
   localparam int POS_DIV_SEL     = 6;
   localparam int POS_PWR_LSB     = 2;
   localparam int PWR_BITS        = 4;
   localparam int POS_ASK_SEL     = 1;
   localparam int POS_CLK_OUT_EN  = 0;
   // Bit count at which the word counts as partly programmed (MSB and MSB-1 in).
   localparam int PARTLY_BITS     = 2;
   // Lock delay in crystal cycles.
   localparam int LOCK_XTAL_CYCLES = 1280;
   // Reset-register hold time and serial clock limit.
   localparam int RESET_MIN_NS    = 10000;
   localparam int CLK_NS          = 4;
   localparam int RESET_MIN_CYC   = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCK_MIN_NS      = 500;
   localparam int SCK_HALF_CYC    = (SCK_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;
   // Controller APB register offsets.
   localparam logic [7:0] OFF_CONFIG  = 8'h00;
   localparam logic [7:0] OFF_CONTROL = 8'h04;
   localparam logic [7:0] OFF_STATUS  = 8'h08;
   // Control command codes written to the control register.
   localparam logic [1:0] CMD_PROGRAM = 2'h1;
   localparam logic [1:0] CMD_OFF     = 2'h2;
   localparam logic [1:0] CMD_RESREG  = 2'h3;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// File: verilog/txcfg_link_if.sv
// Three-wire link between the controller and the transmitter.
`timescale 1ns/100ps
`default_nettype none
interface txcfg_link_if;
   logic enable;         // Enable line, active high.
   logic sck;            // Serial clock.
   logic serial_in_modulation_line; // Data in during loading, modulation after.
   modport ctrl (output enable, output sck, output serial_in_modulation_line);
   modport dev  (input enable, input sck, input serial_in_modulation_line);
endinterface
`default_nettype wire

// File: verilog/txcfg_device.sv
// Transmitter end: serial configuration loader and operating-mode state machine.
// Summary of operation
// - Controller shifts full 32-bit word each session.
// - Bit 31 selects clock-only operation.
// - Bit 30 selects the high oscillator band.
// - Bits 29..15 form carrier adjust word.
// - Bits 14..7 form deviation word.
// - Bit 6 picks divide-by-four, else eight.
// - Bits 5..2 form amplifier power step.
// - Bit 1 selects amplitude keying.
// - Bit 0 enables the output clock driver.
// - Word sent MSB first over three wires.
// - Data captured on serial clock rising edge.
// - Word commits on last falling serial edge.
// - Serial clock stays at or below 2MHz.
// - After load, data line is modulation; clock ignored.
// - Enable and data low enter off mode.
// - Data high, enable low 10us enters reset-register.
// - Reset-register keeps oscillator; amplifier, synthesizer off.
// - Leave reset-register: enable, then data later.
// - Controller returns everything low after transmission.
// - Lock after 1280 crystal cycles, then transmit.
// - Partly programmed after bit 30 falling edge.
// - Clock driver runs only with its enable bit.
`timescale 1ns/100ps
`default_nettype none
module txcfg_device
#(
   parameter int LOCK_CYCLES = txcfg_pkg::LOCK_XTAL_CYCLES
)
(
   // Clock and reset.
   input  wire logic        I_CLK,
   input  wire logic        I_RST_B,
   // Crystal timing inputs.
   input  wire logic        I_XTAL_TICK,       // One-cycle pulse per crystal cycle.
   input  wire logic        I_OSCILLATOR_READY,// Oscillator stable, level.
   // Link.
   txcfg_link_if.dev        link,
   // Decoded configuration.
   output logic [31:0]      O_CONFIG_WORD,
   output logic             O_CLK_ONLY,
   output logic             O_VCO_BAND_HIGH_SELECT,
   output logic [14:0]      O_CARRIER_ADJUST_WORD,
   output logic [7:0]       O_SHIFT_DEVIATION_WORD,
   output logic             O_OUT_DIVIDER_SELECT,
   output logic [3:0]       O_AMP_POWER_STEP,
   output logic             O_AMPLITUDE_KEYING_SELECT,
   // Block enables and operating mode.
   output logic             O_CRYSTAL_OSCILLATOR_ON,
   output logic             O_SYNTH_ON,
   output logic             O_AMP_ON,
   output logic             O_OUTPUT_CLOCK_DRIVER_ON,
   output logic [8:0]       O_MODE
);
   // Operating modes, one-hot.
   typedef enum logic [8:0]
   {
      ST_OFF      = 9'b0_0000_0001,
      ST_START1   = 9'b0_0000_0010,
      ST_START2   = 9'b0_0000_0100,
      ST_AMP_OFF  = 9'b0_0000_1000,   // transmit_amp_off_state.
      ST_AMP_ON   = 9'b0_0001_0000,   // transmit_amp_on_state.
      ST_CLKONLY  = 9'b0_0010_0000,
      ST_RESREG   = 9'b0_0100_0000,
      ST_CONF1    = 9'b0_1000_0000,
      ST_CONF2    = 9'b1_0000_0000
   } txcfg_mode_t;

   // Synchronisers for the three link pins.
   logic [2:0] sync1;                 // First stages, read only by sync2.
   logic [2:0] sync2;                 // Usable pin levels.
   logic [1:0] sck_hist;              // Serial clock history for edges.
   logic       en_d;                  // Delayed enable for its rising edge.
   logic [31:0] shift_reg;            // Bits shifted in so far.
   logic [5:0]  bit_cnt;              // Rising edges taken this session.
   logic        committed;            // Full word has been committed.
   logic        partly;               // MSB-1 falling edge seen.
   logic [31:0] cfg;                  // Active configuration.
   logic [11:0] lock_cnt;             // Crystal cycles since commit.
   logic        locked;               // Synthesizer treated as locked.
   txcfg_mode_t mode;
   txcfg_mode_t next_mode;

   wire en_s      = sync2[2];
   wire sck_s     = sync2[1];
   wire din_s     = sync2[0];
   wire sck_rise  = (sck_hist == 2'b01);
   wire sck_fall  = (sck_hist == 2'b10);
   wire en_rise   = en_s & ~en_d;
   wire loading   = en_s & ~committed;
   wire full      = (bit_cnt == 6'(txcfg_pkg::WORD_BITS));
   wire last_fall = loading & full & sck_fall;
   wire part_fall = loading & sck_fall & (bit_cnt == 6'(txcfg_pkg::PARTLY_BITS));
   wire keyed_on  = ~cfg[txcfg_pkg::POS_ASK_SEL] | din_s;

   // Two-flop synchronisers on the pins.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end
      else
      begin
         sync1 <= {link.enable, link.sck, link.serial_in_modulation_line};
         sync2 <= sync1;
      end
   end

   // Edge history of the synchronised serial clock and enable.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         sck_hist <= 2'h0;
         en_d     <= 1'b0;
      end
      else
      begin
         sck_hist <= {sck_hist[0], sck_s};
         en_d     <= en_s;
      end
   end

   // Serial loader: shift on rising edges, MSB first, commit on last falling edge.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         shift_reg <= txcfg_pkg::RESET_WORD;
         bit_cnt   <= 6'h0;
         committed <= 1'b0;
         partly    <= 1'b0;
         cfg       <= txcfg_pkg::RESET_WORD;
      end
      else if (!en_s || en_rise)
      begin
         bit_cnt   <= 6'h0;
         committed <= 1'b0;
         partly    <= 1'b0;
      end
      else
      begin
         if (loading && sck_rise && !full)
         begin
            shift_reg <= {shift_reg[30:0], din_s};
            bit_cnt   <= bit_cnt + 6'h1;
         end
         if (part_fall)
         begin
            partly <= 1'b1;
         end
         if (last_fall)
         begin
            cfg       <= shift_reg;
            committed <= 1'b1;
         end
      end
   end

   // Lock counter in crystal cycles, started by commit with oscillator ready.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         lock_cnt <= 12'h0;
         locked   <= 1'b0;
      end
      else if (!committed)
      begin
         lock_cnt <= 12'h0;
         locked   <= 1'b0;
      end
      else if (I_OSCILLATOR_READY && I_XTAL_TICK && !locked)
      begin
         if (lock_cnt == 12'(LOCK_CYCLES - 1))
         begin
            locked <= 1'b1;
         end
         lock_cnt <= lock_cnt + 12'h1;
      end
   end

   // Mode transitions.
   always_comb
   begin
      next_mode = mode;
      unique case (mode)
         ST_OFF:
            if (en_s) next_mode = ST_START1;
         ST_START1, ST_CONF1:
            if (!en_s) next_mode = din_s ? ST_RESREG : ST_OFF;
            else if (committed && cfg[txcfg_pkg::POS_CLK_ONLY]) next_mode = ST_CLKONLY;
            else if (partly && !shift_reg[1]) next_mode = (mode == ST_START1) ? ST_START2 : ST_CONF2;
         ST_START2, ST_CONF2:
            if (!en_s) next_mode = din_s ? ST_RESREG : ST_OFF;
            else if (committed && cfg[txcfg_pkg::POS_CLK_ONLY]) next_mode = ST_CLKONLY;
            else if (locked) next_mode = keyed_on ? ST_AMP_ON : ST_AMP_OFF;
         ST_AMP_OFF, ST_AMP_ON:
            if (!en_s) next_mode = din_s ? ST_RESREG : ST_OFF;
            else next_mode = keyed_on ? ST_AMP_ON : ST_AMP_OFF;
         ST_CLKONLY:
            if (!en_s) next_mode = din_s ? ST_RESREG : ST_OFF;
         ST_RESREG:
            if (en_s) next_mode = ST_CONF1;
            else if (!din_s) next_mode = ST_OFF;
         default:
            next_mode = ST_OFF;
      endcase
   end

   // Mode register.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         mode <= ST_OFF;
      else
         mode <= next_mode;
   end

   // Block enables, all registered; decoded fields are wired straight from cfg below.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         O_CRYSTAL_OSCILLATOR_ON  <= 1'b0;
         O_SYNTH_ON               <= 1'b0;
         O_AMP_ON                 <= 1'b0;
         O_OUTPUT_CLOCK_DRIVER_ON <= 1'b0;
      end
      else
      begin
         O_CRYSTAL_OSCILLATOR_ON  <= (next_mode != ST_OFF);
         O_SYNTH_ON               <= (next_mode == ST_START2) || (next_mode == ST_CONF2) ||
                                     (next_mode == ST_AMP_OFF) || (next_mode == ST_AMP_ON);
         O_AMP_ON                 <= (next_mode == ST_AMP_ON);
         O_OUTPUT_CLOCK_DRIVER_ON <= cfg[txcfg_pkg::POS_CLK_OUT_EN] &&
                                     (next_mode != ST_OFF) && (next_mode != ST_START1) &&
                                     (next_mode != ST_START2);
      end
   end

   assign O_CONFIG_WORD             = cfg;
   assign O_CLK_ONLY                = cfg[txcfg_pkg::POS_CLK_ONLY];
   assign O_VCO_BAND_HIGH_SELECT    = cfg[txcfg_pkg::POS_BAND_HIGH];
   assign O_CARRIER_ADJUST_WORD     = cfg[txcfg_pkg::POS_CARRIER_ADJUST_WORD_LSB +: txcfg_pkg::CARRIER_ADJUST_WORD_BITS];
   assign O_SHIFT_DEVIATION_WORD    = cfg[txcfg_pkg::POS_DEV_LSB +: txcfg_pkg::DEV_BITS];
   assign O_OUT_DIVIDER_SELECT      = cfg[txcfg_pkg::POS_DIV_SEL];
   assign O_AMP_POWER_STEP          = cfg[txcfg_pkg::POS_PWR_LSB +: txcfg_pkg::PWR_BITS];
   assign O_AMPLITUDE_KEYING_SELECT = cfg[txcfg_pkg::POS_ASK_SEL];
   assign O_MODE                    = mode;
endmodule
`default_nettype wire

// File: verilog/txcfg_ctrl.sv
// Controller end: APB slave that drives the three-wire link to the transmitter.
`timescale 1ns/100ps
`default_nettype none
module txcfg_ctrl
#(
   parameter int HALF_CYC  = txcfg_pkg::SCK_HALF_CYC,
   parameter int RESET_CYC = txcfg_pkg::RESET_MIN_CYC
)
(
   // Clock and reset.
   input  wire logic        I_CLK,
   input  wire logic        I_RST_B,
   // APB slave.
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // Modulation data during transmit.
   input  wire logic        I_TX_DATA,
   // Link.
   txcfg_link_if.ctrl       link
);
   typedef enum logic [5:0]
   {
      C_IDLE  = 6'b00_0001,
      C_LOW   = 6'b00_0010,   // Clock low half, data set up.
      C_HIGH  = 6'b00_0100,   // Clock high half.
      C_TX    = 6'b00_1000,   // Word sent, data line follows modulation.
      C_RESD  = 6'b01_0000,   // Enable low, data high, waiting.
      C_RESEN = 6'b10_0000    // Enable high, data held low, waiting.
   } txcfg_cstate_t;

   txcfg_cstate_t st;
   logic [31:0] word;         // Word to send.
   logic [31:0] sh;           // Shift copy.
   logic [5:0]  sent;         // Bits sent.
   logic [15:0] tmr;          // Phase timer.
   logic        en_o;
   logic        sck_o;
   logic        dat_o;

   wire acc    = I_PSEL & I_PENABLE;
   wire wr     = acc & I_PWRITE;
   wire hit_c  = (I_PADDR == txcfg_pkg::OFF_CONFIG);
   wire hit_k  = (I_PADDR == txcfg_pkg::OFF_CONTROL);
   wire hit_s  = (I_PADDR == txcfg_pkg::OFF_STATUS);
   wire busy   = (st != C_IDLE) && (st != C_TX);
   wire cmd_go = wr & hit_k & ~busy;
   wire [1:0] cmd = I_PWDATA[1:0];
   wire tmr_done = (tmr == 16'h0);

   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = acc & ~(hit_c | hit_k | hit_s);

   // Read data: config word, or status with state and bit count.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         O_PRDATA <= 32'h0000_0000;
      else if (I_PSEL && !I_PENABLE && !I_PWRITE)
         O_PRDATA <= hit_c ? word : hit_s ? {18'h0, sent, 2'h0, st} : 32'h0000_0000;
   end

   // Configuration word store.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         word <= txcfg_pkg::RESET_WORD;
      else if (wr && hit_c)
         word <= I_PWDATA;
   end

   // Link sequencer.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         st    <= C_IDLE;
         sh    <= 32'h0000_0000;
         sent  <= 6'h0;
         tmr   <= 16'h0;
         en_o  <= 1'b0;
         sck_o <= 1'b0;
         dat_o <= 1'b0;
      end
      else
      begin
         if (!tmr_done)
            tmr <= tmr - 16'h1;
         unique case (st)
            C_IDLE, C_TX:
            begin
               if (st == C_TX)
                  dat_o <= I_TX_DATA;
               if (cmd_go && cmd == txcfg_pkg::CMD_PROGRAM)
               begin
                  en_o  <= 1'b1;
                  sh    <= {word[30:0], 1'b0};
                  dat_o <= word[31];
                  sent  <= 6'h0;
                  sck_o <= 1'b0;
                  tmr   <= 16'(HALF_CYC);
                  st    <= C_LOW;
               end
               else if (cmd_go && cmd == txcfg_pkg::CMD_OFF)
               begin
                  en_o  <= 1'b0;
                  sck_o <= 1'b0;
                  dat_o <= 1'b0;
                  st    <= C_IDLE;
               end
               else if (cmd_go && cmd == txcfg_pkg::CMD_RESREG)
               begin
                  en_o  <= 1'b0;
                  sck_o <= 1'b0;
                  dat_o <= 1'b1;
                  tmr   <= 16'(RESET_CYC);
                  st    <= C_RESD;
               end
            end
            C_RESD:
               if (tmr_done)
               begin
                  en_o <= 1'b1;
                  dat_o <= 1'b0;
                  tmr  <= 16'(RESET_CYC);
                  st   <= C_RESEN;
               end
            C_RESEN:
               if (tmr_done)
               begin
                  dat_o <= word[31];
                  sh    <= {word[30:0], 1'b0};
                  sent  <= 6'h0;
                  tmr   <= 16'(HALF_CYC);
                  st    <= C_LOW;
               end
            C_LOW:
               if (tmr_done)
               begin
                  sck_o <= 1'b1;
                  sent  <= sent + 6'h1;
                  tmr   <= 16'(HALF_CYC);
                  st    <= C_HIGH;
               end
            C_HIGH:
               if (tmr_done)
               begin
                  sck_o <= 1'b0;
                  tmr   <= 16'(HALF_CYC);
                  if (sent == 6'(txcfg_pkg::WORD_BITS))
                     st <= C_TX;
                  else
                  begin
                     dat_o <= sh[31];
                     sh    <= {sh[30:0], 1'b0};
                     st    <= C_LOW;
                  end
               end
            default:
               st <= C_IDLE;
         endcase
      end
   end

   assign link.enable                    = en_o;
   assign link.sck                       = sck_o;
   assign link.serial_in_modulation_line = dat_o;
endmodule
`default_nettype wire

// File: test/txcfg_link_monitor.sv
// Checker for the three link wires between controller and transmitter.
`timescale 1ns/100ps
`default_nettype none
module txcfg_link_monitor
(
   // Clock and reset.
   input wire logic I_CLK,
   input wire logic I_RST_B,
   // Link wires.
   input wire logic enable,
   input wire logic sck,
   input wire logic serial_in_modulation_line
);
   logic [5:0] bit_cnt; // Serial clock rises seen since enable rose.
   wire resreg_lvl = !enable && serial_in_modulation_line; // Reset-register request on the wires.
   wire data_low   = !serial_in_modulation_line;           // Data line held low.
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   // Count rises within a session; it saturates so a runaway stays visible.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         bit_cnt <= 6'h00;
      end
      else if (!enable)
      begin
         bit_cnt <= 6'h00;
      end
      else if ($rose(sck) && bit_cnt != 6'h3F)
      begin
         bit_cnt <= bit_cnt + 6'h01;
      end
   end
   sck_idle_a: assert property (!enable |-> !sck)
      else $error("serial clock moved with enable low");
   sck_high_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
      else $error("serial clock high phase wrong");
   sck_low_a: assert property ($fell(sck) |-> !sck [*4])
      else $error("serial clock low phase too short");
   data_hold_a: assert property ($rose(sck) |=> $stable(serial_in_modulation_line) [*3])
      else $error("data moved while serial clock high");
   bit_limit_a: assert property (bit_cnt <= 6'h20)
      else $error("more than a word of clocks sent");
   whole_word_a: assert property ($fell(enable) |-> bit_cnt == 6'h20 || bit_cnt == 6'h00)
      else $error("session ended mid word");
   resreg_hold_a: assert property (!enable && $rose(serial_in_modulation_line) |-> resreg_lvl [*8])
      else $error("reset register entry too short");
   rise_order_a: assert property ($rose(enable) && $past(serial_in_modulation_line) |-> data_low [*8])
      else $error("data rose too soon after enable");
   cover property ($rose(sck) && bit_cnt == 6'h1F);
   cover property ($rose(enable) && $past(serial_in_modulation_line));
   cover property ($fell(enable) && bit_cnt == 6'h20);
endmodule
`default_nettype wire

// File: test/tx_config_shift_and_mode_fsm_tb.sv
// Testbench: APB-driven controller loading the transmitter over the link.
`timescale 1ns/100ps
`default_nettype none
module tx_config_shift_and_mode_fsm_tb;
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic pready, pslverr, err, tx_data = 0, tick = 0, rdy = 0, sck_d = 0;
   logic [1:0] tick_cnt = 2'h0;
   logic [31:0] cfg, wword = 32'h0000_0000;
   logic [14:0] carrier;
   logic [7:0] dev;
   logic [3:0] amp_power_step;
   logic [8:0] mode;
   logic clk_only, band, div, ask, xo_on, syn_on, amp_on, drv_on;
   int wcnt = 0, error_cnt = 0, checks = 0;
   txcfg_link_if lnk ();
   txcfg_ctrl #(.HALF_CYC(3), .RESET_CYC(10)) u_txcfg_ctrl (.I_CLK(clk), .I_RST_B(rst_b),
      .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TX_DATA(tx_data), .link(lnk));
   txcfg_device #(.LOCK_CYCLES(8)) u_txcfg_device (.I_CLK(clk), .I_RST_B(rst_b), .I_XTAL_TICK(tick),
      .I_OSCILLATOR_READY(rdy), .link(lnk), .O_CONFIG_WORD(cfg), .O_CLK_ONLY(clk_only),
      .O_VCO_BAND_HIGH_SELECT(band), .O_CARRIER_ADJUST_WORD(carrier), .O_SHIFT_DEVIATION_WORD(dev),
      .O_OUT_DIVIDER_SELECT(div), .O_AMP_POWER_STEP(amp_power_step), .O_AMPLITUDE_KEYING_SELECT(ask),
      .O_CRYSTAL_OSCILLATOR_ON(xo_on), .O_SYNTH_ON(syn_on), .O_AMP_ON(amp_on),
      .O_OUTPUT_CLOCK_DRIVER_ON(drv_on), .O_MODE(mode));
   txcfg_link_monitor u_txcfg_link_monitor (.I_CLK(clk), .I_RST_B(rst_b), .enable(lnk.enable),
      .sck(lnk.sck), .serial_in_modulation_line(lnk.serial_in_modulation_line));
   // A 4 ns clock and a crystal tick every fourth cycle.
   initial
   begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      tick_cnt <= tick_cnt + 2'h1;
      tick <= (tick_cnt == 2'h3);
   end
   // Independent capture of the wire, so bit order is judged on the pins.
   always @(posedge clk)
   begin
      sck_d <= lnk.sck;
      if (!lnk.enable)
         wcnt <= 0;
      else if (lnk.sck && !sck_d)
      begin
         wword <= {wword[30:0], lnk.serial_in_modulation_line};
         wcnt <= wcnt + 1;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   // One APB transfer; entered and left just after a rising edge.
   // Only the watchdog ends a wait for pready.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_mode(input int b, input int lim);
      int n;
      n = 0;
      while (mode[b] !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      chk(32'(mode[b]), 32'h1, "mode not reached");
   endtask
   // Load an FSK word and follow it through partial load, commit and lock.
   task automatic t_program();
      logic [31:0] w;
      int n;
      w = 32'h5A5A_C3B5;
      n = 0;
      apb(1'b1, txcfg_pkg::OFF_CONFIG, w);
      apb(1'b0, txcfg_pkg::OFF_CONFIG, 32'h0000_0000);
      chk(q, w, "config readback");
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk(32'(err), 32'h1, "unmapped not refused");
      apb(1'b1, txcfg_pkg::OFF_CONTROL, 32'(txcfg_pkg::CMD_PROGRAM));
      // An off command before the first clock rise must be refused while the controller is busy.
      apb(1'b1, txcfg_pkg::OFF_CONTROL, 32'(txcfg_pkg::CMD_OFF));
      chk(32'(lnk.enable), 32'h1, "command taken while busy");
      while (wcnt < 4 && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      chk(32'({mode[2], syn_on}), 32'h3, "synthesizer not started early");
      while (wcnt < 32 && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      // Stop where the last falling edge shows on the wire; the commit lags it by the synchronisers.
      while (lnk.sck !== 1'b0 && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      chk(32'(wcnt), 32'h20, "bits on the wire");
      chk(cfg, txcfg_pkg::RESET_WORD, "commit before last fall");
      repeat (20) @(posedge clk);
      chk(cfg, w, "word not committed");
      chk(wword, w, "wire order");
      chk(32'({clk_only, band}), 32'(w[31:30]), "mode and band bits");
      chk(32'(carrier), 32'(w[29:15]), "carrier word");
      chk(32'(dev), 32'(w[14:7]), "deviation word");
      chk(32'({div, amp_power_step, ask}), 32'(w[6:1]), "divider power keying");
      repeat (40) @(posedge clk);
      chk(32'(mode[4:3]), 32'h0, "transmit without ready");
      rdy <= 1'b1;
      repeat (20) @(posedge clk);
      chk(32'(mode[4:3]), 32'h0, "lock too early");
      wait_mode(4, 40);
      chk(32'({syn_on, amp_on, drv_on}), 32'h7, "transmit enables");
      apb(1'b0, txcfg_pkg::OFF_STATUS, 32'h0000_0000);
      chk(32'(q[13:8]), 32'h20, "bits sent");
      $display("program test done");
   endtask
   // Off, then an ASK word keyed by the modulation line.
   task automatic t_ask();
      apb(1'b1, txcfg_pkg::OFF_CONTROL, 32'(txcfg_pkg::CMD_OFF));
      wait_mode(0, 100);
      repeat (2) @(posedge clk);
      chk(32'({xo_on, syn_on, amp_on, drv_on}), 32'h0, "off enables");
      chk(32'({lnk.enable, lnk.sck, lnk.serial_in_modulation_line}), 32'h0, "off lines");
      apb(1'b1, txcfg_pkg::OFF_CONFIG, 32'h1234_5672);
      apb(1'b1, txcfg_pkg::OFF_CONTROL, 32'(txcfg_pkg::CMD_PROGRAM));
      wait_mode(3, 1000);
      repeat (2) @(posedge clk);
      chk(32'({amp_on, drv_on}), 32'h0, "ask low, driver off");
      tx_data <= 1'b1;
      wait_mode(4, 20);
      repeat (2) @(posedge clk);
      chk(32'(amp_on), 32'h1, "ask high");
      tx_data <= 1'b0;
      wait_mode(3, 20);
      $display("ask test done");
   endtask
   // Reprogram through reset-register mode into clock-only operation, then into transmit.
   task automatic t_resreg();
      logic [31:0] w;
      w = 32'h8765_4321;
      apb(1'b1, txcfg_pkg::OFF_CONFIG, w);
      apb(1'b1, txcfg_pkg::OFF_CONTROL, 32'(txcfg_pkg::CMD_RESREG));
      wait_mode(6, 100);
      repeat (2) @(posedge clk);
      chk(32'({xo_on, syn_on, amp_on}), 32'h4, "reset register enables");
      wait_mode(5, 1000);
      repeat (2) @(posedge clk);
      chk(cfg, w, "reprogrammed word");
      chk(32'({xo_on, syn_on, amp_on, drv_on}), 32'h9, "clock only enables");
      // A normal word must start the synthesizer while the word is still coming in.
      w = 32'h1234_5671;
      apb(1'b1, txcfg_pkg::OFF_CONFIG, w);
      apb(1'b1, txcfg_pkg::OFF_CONTROL, 32'(txcfg_pkg::CMD_RESREG));
      wait_mode(8, 1000);
      chk(32'({syn_on, amp_on, drv_on}), 32'h5, "partly programmed enables");
      wait_mode(4, 1000);
      chk(cfg, w, "second reprogrammed word");
      $display("reset register test done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog well beyond the roughly 1300 cycles the tests need.
   initial
   begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_program();
      t_ask();
      t_resreg();
      report_and_stop();
   end
endmodule
`default_nettype wire
